// file: hdl/ebr_block.sv
// embedded block ram: 4608-bit array with two ports and six uses
//
// Functional notes
// - write data, address, strobe always registered first
// - optional output register; bypass skips one cycle
// - modes: tdp, sdp, sp, rom, fifo, shift
// - array holds 4608 bits including parity
// - nine shapes; 128-deep refused in tdp
// - parity bit per byte, stored only
// - byte masks keep unwritten bytes
// - packed: two half single-port memories, one clock
// - address hold freezes address register
// - clears touch output registers only; power-up cleared
// - same-port read during write returns new data
// - mixed-port read during write returns old data
// - contents preloaded from configuration image
// - read/write clocks map onto one system clock
// - single clock drives all registers
// - shift use: write half-cycle after read
`timescale 1ns/1ps
`default_nettype none
module ebr_block #(
  parameter logic [4607:0] INIT_IMAGE = 4608'h0
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // static configuration
  input  wire ebr_pkg::ebr_cfg_t cfg,
  // user ports
  input  wire ebr_pkg::ebr_port_t port_a,
  input  wire ebr_pkg::ebr_port_t port_b,
  // read data and status
  output logic [35:0]            q_a,
  output logic [35:0]            q_b,
  output logic                   fifo_full,
  output logic                   fifo_empty,
  output logic                   cfg_refused
);
  ebr_pkg::ebr_port_t in_r    [2];
  ebr_pkg::ebr_port_t port_in [2];
  logic [35:0]        pipe_r  [2];
  logic [35:0]        q_r     [2];
  logic [35:0]        rd_word [2];
  logic [35:0]        new_word[2];
  logic [35:0]        bwe     [2];
  logic [11:0]        eff_addr[2];
  logic [12:0]        base    [2];
  logic [1:0]         wen;
  logic [1:0]         rden;
  logic [5:0]         pw;
  logic [11:0]        mask;
  logic [11:0]        half;
  logic               par;
  logic               deep128;
  logic               run_r;
  logic               refused_r;
  logic               full_r;
  logic               empty_r;
  logic               pop;
  logic [12:0]        wr_ptr_r;
  logic [12:0]        rd_ptr_r;
  logic [12:0]        cnt_r;
  logic [12:0]        cnt_nxt;
  logic [4607:0]      mem_r = INIT_IMAGE;

  assign port_in[0] = port_a;
  assign port_in[1] = port_b;

  // physical width per shape; 8/16/32 use 9-bit lanes with parity left empty
  always_comb begin
    pw   = 6'h01;
    mask = 12'hfff;
    par  = 1'b0;
    case (cfg.shape)
      ebr_pkg::EBR_4KX1:   begin pw = 6'h01; mask = 12'hfff; end
      ebr_pkg::EBR_2KX2:   begin pw = 6'h02; mask = 12'h7ff; end
      ebr_pkg::EBR_1KX4:   begin pw = 6'h04; mask = 12'h3ff; end
      ebr_pkg::EBR_512X8:  begin pw = 6'h09; mask = 12'h1ff; end
      ebr_pkg::EBR_512X9:  begin pw = 6'h09; mask = 12'h1ff; par = 1'b1; end
      ebr_pkg::EBR_256X16: begin pw = 6'h12; mask = 12'h0ff; end
      ebr_pkg::EBR_256X18: begin pw = 6'h12; mask = 12'h0ff; par = 1'b1; end
      ebr_pkg::EBR_128X32: begin pw = 6'h24; mask = 12'h07f; end
      ebr_pkg::EBR_128X36: begin pw = 6'h24; mask = 12'h07f; par = 1'b1; end
      default:             begin pw = 6'h01; mask = 12'hfff; end
    endcase
  end
  assign half    = mask ^ (mask >> 1);
  assign deep128 = (cfg.shape == ebr_pkg::EBR_128X32) || (cfg.shape == ebr_pkg::EBR_128X36);

  // writes wait one cycle after reset so stale input registers never land
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      run_r     <= 1'b0;
      refused_r <= 1'b0;
    end else begin
      run_r     <= 1'b1;
      refused_r <= (cfg.mode == ebr_pkg::EBR_TDP) && deep128;
    end
  end

  // input stage: no reset and no clear, as on the real array
  always_ff @(posedge clk_sys) begin
    for (int p = 0; p < 2; p++) begin
      if (!port_in[p].ahold) begin
        in_r[p].addr <= port_in[p].addr;
      end
      in_r[p].wdata <= port_in[p].wdata;
      in_r[p].be    <= port_in[p].be;
      in_r[p].we    <= port_in[p].we;
      in_r[p].rd    <= port_in[p].rd;
      in_r[p].ahold <= port_in[p].ahold;
      in_r[p].clr   <= port_in[p].clr;
    end
  end

  assign pop = run_r && (cfg.mode == ebr_pkg::EBR_FIFO) && in_r[1].rd && !empty_r;

  // per-mode address, write and read steering
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      eff_addr[p] = in_r[p].addr & mask;
      if (cfg.mode == ebr_pkg::EBR_SP && cfg.packed_sp) begin
        eff_addr[p] = (eff_addr[p] & ~half) | (p == 1 ? half : 12'h000);
      end
    end
    wen  = 2'b00;
    rden = 2'b00;
    case (cfg.mode)
      ebr_pkg::EBR_TDP: begin
        wen  = {in_r[1].we, in_r[0].we} & {2{!refused_r}};
        rden = {in_r[1].rd, in_r[0].rd};
      end
      ebr_pkg::EBR_SDP: begin
        wen  = {1'b0, in_r[0].we};
        rden = {in_r[1].rd, 1'b0};
      end
      ebr_pkg::EBR_SP: begin
        wen  = {in_r[1].we & cfg.packed_sp, in_r[0].we};
        rden = {in_r[1].rd & cfg.packed_sp, in_r[0].rd};
      end
      ebr_pkg::EBR_ROM: begin
        rden = {1'b0, in_r[0].rd};
      end
      ebr_pkg::EBR_FIFO: begin
        eff_addr[0] = wr_ptr_r[11:0];
        eff_addr[1] = rd_ptr_r[11:0];
        wen  = {1'b0, in_r[0].we & !full_r};
        rden = {pop, 1'b0};
      end
      ebr_pkg::EBR_SHIFT: begin
        eff_addr[0] = wr_ptr_r[11:0];
        wen  = {1'b0, in_r[0].we};
        rden = {1'b0, in_r[0].we};
      end
      default: begin
        wen  = 2'b00;
        rden = 2'b00;
      end
    endcase
    wen = wen & {2{run_r}};
  end

  // bit-level read, byte mask and merge for each port
  for (genvar p = 0; p < 2; p++) begin : g_port
    assign base[p] = 13'(eff_addr[p] * pw);
    for (genvar i = 0; i < 36; i++) begin : g_bit
      localparam int LANE = i / 9;
      logic live;
      assign live = (6'(i) < pw) && (par || (i % 9) != 8);
      assign rd_word[p][i] = live ? mem_r[13'(base[p] + 13'(i))] : 1'b0;
      assign bwe[p][i] = wen[p] && live &&
                         (pw < 6'h09 ? in_r[p].be[0] : in_r[p].be[LANE]);
      assign new_word[p][i] = bwe[p][i] ? in_r[p].wdata[i] : rd_word[p][i];
    end
  end

  // port b is written after port a in the loop, so b wins a same-word collision
  always_ff @(posedge clk_sys) begin
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 36; i++) begin
        if (bwe[p][i]) begin
          mem_r[13'(base[p] + 13'(i))] <= in_r[p].wdata[i];
        end
      end
    end
  end

  // output stage: the only registers that clear
  always_ff @(posedge clk_sys) begin
    for (int p = 0; p < 2; p++) begin
      if (!rst_n || in_r[p].clr) begin
        pipe_r[p] <= ebr_pkg::EBR_Q_RST;
        q_r[p]    <= ebr_pkg::EBR_Q_RST;
      end else begin
        if (rden[p]) begin
          // shift taps read the old word: the write sits half a cycle later
          pipe_r[p] <= (cfg.mode == ebr_pkg::EBR_SHIFT) ? rd_word[p] : new_word[p];
        end
        if (cfg.outreg) begin
          q_r[p] <= pipe_r[p];
        end else if (rden[p]) begin
          q_r[p] <= (cfg.mode == ebr_pkg::EBR_SHIFT) ? rd_word[p] : new_word[p];
        end
      end
    end
  end

  // fifo write pointer doubles as the shift-register tap pointer
  always_comb begin
    cnt_nxt = cnt_r;
    if (cfg.mode == ebr_pkg::EBR_FIFO) begin
      cnt_nxt = 13'(cnt_r + {12'h000, wen[0]} - {12'h000, pop});
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_ptr_r <= ebr_pkg::EBR_PTR_RST;
      rd_ptr_r <= ebr_pkg::EBR_PTR_RST;
      cnt_r    <= ebr_pkg::EBR_PTR_RST;
      full_r   <= 1'b0;
      empty_r  <= 1'b1;
    end else begin
      if (wen[0] && (cfg.mode == ebr_pkg::EBR_FIFO || cfg.mode == ebr_pkg::EBR_SHIFT)) begin
        wr_ptr_r <= {1'b0, 12'(wr_ptr_r[11:0] + 12'h001) & mask};
      end
      if (pop) begin
        rd_ptr_r <= {1'b0, 12'(rd_ptr_r[11:0] + 12'h001) & mask};
      end
      cnt_r   <= cnt_nxt;
      full_r  <= cnt_nxt == 13'({1'b0, mask} + 13'h0001);
      empty_r <= cnt_nxt == ebr_pkg::EBR_PTR_RST;
    end
  end

  assign q_a         = q_r[0];
  assign q_b         = q_r[1];
  assign fifo_full   = full_r;
  assign fifo_empty  = empty_r;
  assign cfg_refused = refused_r;

  a_addr_capture: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !port_a.ahold |=> in_r[0].addr == $past(port_a.addr))
    else $error("address not captured");
  a_addr_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    port_a.ahold |=> $stable(in_r[0].addr))
    else $error("held address moved");
  a_bypass_timing: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!cfg.outreg && rden[0] && !in_r[0].clr && cfg.mode == ebr_pkg::EBR_SP) |=>
    q_a == $past(new_word[0]))
    else $error("bypassed read data wrong");
  a_outreg_timing: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cfg.outreg && rden[1] && cfg.mode != ebr_pkg::EBR_SHIFT && !in_r[1].clr) ##1
    (!in_r[1].clr && !rden[1]) |=> q_b == $past(new_word[1], 2))
    else $error("registered read data wrong");
  a_clear_output: assert property (@(posedge clk_sys) disable iff (!rst_n)
    in_r[1].clr |=> q_b == ebr_pkg::EBR_Q_RST && pipe_r[1] == ebr_pkg::EBR_Q_RST)
    else $error("output not cleared");
  a_same_port_new: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wen[0] && rden[0] && in_r[0].be == 4'hf && cfg.shape == ebr_pkg::EBR_128X36 &&
     !cfg.outreg && !in_r[0].clr && cfg.mode != ebr_pkg::EBR_SHIFT) |=>
    q_a == $past(in_r[0].wdata))
    else $error("same-port read not new data");
  a_mixed_port_old: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cfg.mode == ebr_pkg::EBR_SDP && wen[0] && rden[1] && eff_addr[0] == eff_addr[1] &&
     !in_r[1].clr) |=> pipe_r[1] == $past(rd_word[1]))
    else $error("mixed-port read not old data");
  a_deep_refused: assert property (@(posedge clk_sys) disable iff (!rst_n)
    refused_r |-> wen == 2'b00)
    else $error("write in refused shape");
  a_byte_mask: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wen[0] && !wen[1] && !in_r[0].be[0] && cfg.shape == ebr_pkg::EBR_128X36) |=>
    mem_r[$past(base[0]) +: 9] == $past(mem_r[base[0] +: 9]))
    else $error("masked byte changed");
  a_empty_no_pop: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (empty_r && cfg.mode == ebr_pkg::EBR_FIFO && in_r[1].rd) |=>
    rd_ptr_r == $past(rd_ptr_r))
    else $error("pop from empty fifo");
endmodule
`default_nettype wire

// file: hdl/ebr_pkg.sv
// shared types and constants of the embedded block ram
package ebr_pkg;
  localparam int          EBR_BITS   = 4608;
  localparam int          EBR_DW     = 36;
  localparam int          EBR_AW     = 12;
  localparam int          EBR_LANES  = 4;
  localparam int          EBR_LANE_W = 9;
  localparam int          EBR_PW_W   = 6;
  localparam int          EBR_IDX_W  = 13;
  localparam logic [35:0] EBR_Q_RST  = 36'h0;
  localparam logic [12:0] EBR_PTR_RST = 13'h0;

  typedef enum logic [5:0] {
    EBR_TDP   = 6'h01,
    EBR_SDP   = 6'h02,
    EBR_SP    = 6'h04,
    EBR_ROM   = 6'h08,
    EBR_FIFO  = 6'h10,
    EBR_SHIFT = 6'h20
  } ebr_mode_t;

  typedef enum logic [3:0] {
    EBR_4KX1   = 4'h0,
    EBR_2KX2   = 4'h1,
    EBR_1KX4   = 4'h2,
    EBR_512X8  = 4'h3,
    EBR_512X9  = 4'h4,
    EBR_256X16 = 4'h5,
    EBR_256X18 = 4'h6,
    EBR_128X32 = 4'h7,
    EBR_128X36 = 4'h8
  } ebr_shape_t;

  typedef struct packed {
    ebr_mode_t  mode;
    ebr_shape_t shape;
    logic       outreg;
    logic       packed_sp;
  } ebr_cfg_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [35:0] wdata;
    logic [3:0]  be;
    logic        we;
    logic        rd;
    logic        ahold;
    logic        clr;
  } ebr_port_t;
endpackage

// file: verification/ebr_user_model.sv
// fabric-side user logic model feeding both ports of the block
`timescale 1ns/1ps
`default_nettype none
module ebr_user_model (
  // requests from the bench
  input  wire ebr_pkg::ebr_port_t req_a,
  input  wire ebr_pkg::ebr_port_t req_b,
  // block state seen by the user logic
  input  wire ebr_pkg::ebr_mode_t mode,
  input  wire logic               fifo_empty,
  // into the block
  output var ebr_pkg::ebr_port_t  port_a,
  output var ebr_pkg::ebr_port_t  port_b
);
  always_comb begin
    port_a = req_a;
    port_b = req_b;
    // push with pop on an empty fifo is unsupported, so the pop is held back
    if (mode == ebr_pkg::EBR_FIFO && req_a.we && req_b.rd && fifo_empty) begin
      port_b.rd = 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: verification/ebr_block_test.sv
// self-checking testbench of the embedded block ram
`timescale 1ns/1ps
`default_nettype none
module ebr_block_test;
  typedef struct {int due; bit pb; logic [35:0] val;} ebr_note_t;
  logic               clk_sys;
  logic               rst_n;
  ebr_pkg::ebr_cfg_t  cfg;
  ebr_pkg::ebr_port_t req_a, req_b, port_a, port_b;
  logic [35:0]        q_a, q_b, w0, w1, mrg;
  logic               fifo_full, fifo_empty, cfg_refused;
  int                 n_fail, checks, cyc;
  ebr_note_t          notes[$];
  ebr_note_t          cur;

  // two preloaded words at addresses 0 and 1 of the 36-bit shape
  ebr_block #(.INIT_IMAGE(4608'h0abcdef01_123456789)) DUT (.clk_sys(clk_sys), .rst_n(rst_n),
    .cfg(cfg), .port_a(port_a), .port_b(port_b), .q_a(q_a), .q_b(q_b),
    .fifo_full(fifo_full), .fifo_empty(fifo_empty), .cfg_refused(cfg_refused));
  ebr_user_model u_user (.req_a(req_a), .req_b(req_b), .mode(cfg.mode),
    .fifo_empty(fifo_empty), .port_a(port_a), .port_b(port_b));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) cyc <= cyc + 1;

  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up();
    // an expectation that never came due is a miss as well
    n_fail += notes.size();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  function automatic ebr_pkg::ebr_port_t rq(input logic [11:0] ad, input logic [35:0] d,
      input logic [3:0] be, input logic we, input logic rd, input logic hold, input logic clr);
    rq = '{addr:ad, wdata:d, be:be, we:we, rd:rd, ahold:hold, clr:clr};
  endfunction
  // inputs move only at the falling edge, away from the sampling edge
  task automatic step(input ebr_pkg::ebr_port_t pa, input ebr_pkg::ebr_port_t pb);
    @(negedge clk_sys);
    req_a = pa;
    req_b = pb;
  endtask
  task automatic note(input bit pb, input logic [35:0] v, input int lat);
    notes.push_back('{cyc + lat, pb, v});
  endtask
  task automatic restart(input ebr_pkg::ebr_cfg_t c);
    @(negedge clk_sys);
    rst_n = 1'b0;
    cfg = c;
    req_a = '0;
    req_b = '0;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (2) @(negedge clk_sys);
  endtask

  // scoreboard: oldest note is compared when its result is due
  always @(negedge clk_sys) begin
    while (notes.size() > 0 && notes[0].due == cyc) begin
      cur = notes.pop_front();
      chk(cur.pb ? "q_b" : "q_a", cur.val, cur.pb ? q_b : q_a);
    end
  end

  initial begin
    #(2000 * 50);
    n_fail++;
    wrap_up();
  end

  initial begin
    rst_n = 1'b0;
    req_a = '0;
    req_b = '0;
    cyc = 0;
    n_fail = 0;
    checks = 0;
    cfg = '{ebr_pkg::EBR_SP, ebr_pkg::EBR_128X36, 1'b0, 1'b0};
    void'($urandom(32'hac06));
    // single port, 128x36, output register bypassed
    restart('{ebr_pkg::EBR_SP, ebr_pkg::EBR_128X36, 1'b0, 1'b0});
    w0 = {4'($urandom), $urandom};
    w1 = {4'($urandom), $urandom};
    mrg = (w0 & ~36'hff803fe00) | (w1 & 36'hff803fe00);
    step(rq(12'h1, '0, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0), '0);
    note(0, 36'h0abcdef01, 2);
    step(rq(12'h5, w0, 4'hf, 1'b1, 1'b1, 1'b0, 1'b0), '0);
    note(0, w0, 2);
    step(rq(12'h5, w1, 4'ha, 1'b1, 1'b0, 1'b0, 1'b0), '0);
    step(rq(12'h5, '0, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0), '0);
    note(0, mrg, 2);
    step(rq(12'h1, '0, 4'h0, 1'b0, 1'b1, 1'b1, 1'b0), '0);
    note(0, mrg, 2);
    step(rq(12'h0, '0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b1), '0);
    note(0, 36'h0, 2);
    repeat (4) step('0, '0);
    // simple dual port, 256x18, output register on
    restart('{ebr_pkg::EBR_SDP, ebr_pkg::EBR_256X18, 1'b1, 1'b0});
    chk("cfg_refused", 36'h0, {35'h0, cfg_refused});
    w0 = {18'h0, 18'($urandom)};
    step(rq(12'h5, w0, 4'hf, 1'b1, 1'b0, 1'b0, 1'b0), rq(12'h5, '0, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0));
    note(1, 36'h0, 3);
    step('0, rq(12'h5, '0, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0));
    note(1, w0, 3);
    step('0, '0);
    step('0, rq(12'h0, '0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b1));
    note(1, 36'h0, 2);
    repeat (5) step('0, '0);
    // tdp refuses the 128-deep shapes and rom ignores writes: the preload survives both
    for (int m = 0; m < 2; m++) begin
      restart('{m ? ebr_pkg::EBR_ROM : ebr_pkg::EBR_TDP, ebr_pkg::EBR_128X36, 1'b0, 1'b0});
      chk("cfg_refused", {35'h0, m == 0}, {35'h0, cfg_refused});
      step(rq(12'h1, w0, 4'hf, 1'b1, 1'b0, 1'b0, 1'b0), '0);
      step(rq(12'h1, '0, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0), '0);
      note(0, 36'h0abcdef01, 2);
      repeat (4) step('0, '0);
    end
    // fifo 512x9: first push comes with a pop while empty
    restart('{ebr_pkg::EBR_FIFO, ebr_pkg::EBR_512X9, 1'b0, 1'b0});
    chk("fifo_empty", 36'h1, {35'h0, fifo_empty});
    w0 = {27'h0, 9'($urandom)};
    w1 = {27'h0, 9'($urandom)};
    step(rq(12'h0, w0, 4'h1, 1'b1, 1'b0, 1'b0, 1'b0), rq(12'h0, '0, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0));
    step(rq(12'h0, w1, 4'h1, 1'b1, 1'b0, 1'b0, 1'b0), '0);
    repeat (2) step('0, '0);
    step('0, rq(12'h0, '0, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0));
    note(1, w0, 2);
    step('0, rq(12'h0, '0, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0));
    note(1, w1, 2);
    repeat (4) step('0, '0);
    chk("fifo_empty", 36'h1, {35'h0, fifo_empty});
    // a pop on an empty fifo is dropped, so q_b keeps the last word
    step('0, rq(12'h0, '0, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0));
    note(1, w1, 2);
    repeat (4) step('0, '0);
    // fifo 128x36: full only once a whole depth is stored
    restart('{ebr_pkg::EBR_FIFO, ebr_pkg::EBR_128X36, 1'b0, 1'b0});
    for (int k = 0; k < 128; k++) begin
      step(rq(12'h0, {4'($urandom), $urandom}, 4'hf, 1'b1, 1'b0, 1'b0, 1'b0), '0);
    end
    step('0, '0);
    chk("fifo_full", 36'h0, {35'h0, fifo_full});
    step('0, '0);
    chk("fifo_full", 36'h1, {35'h0, fifo_full});
    repeat (2) step('0, '0);
    // two packed single-port memories: one address lands in separate halves
    restart('{ebr_pkg::EBR_SP, ebr_pkg::EBR_256X18, 1'b0, 1'b1});
    w0 = {18'h0, 18'($urandom)};
    w1 = {18'h0, 18'($urandom)};
    step(rq(12'h3, w0, 4'hf, 1'b1, 1'b0, 1'b0, 1'b0), rq(12'h3, w1, 4'hf, 1'b1, 1'b0, 1'b0, 1'b0));
    step(rq(12'h3, '0, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0), rq(12'h3, '0, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0));
    note(0, w0, 2);
    note(1, w1, 2);
    repeat (4) step('0, '0);
    // shift register 128x36: each tap returns the word pushed one depth earlier
    restart('{ebr_pkg::EBR_SHIFT, ebr_pkg::EBR_128X36, 1'b0, 1'b0});
    for (int k = 0; k < 130; k++) begin
      mrg = {4'($urandom), $urandom};
      if (k == 0) w0 = mrg;
      if (k == 1) w1 = mrg;
      step(rq(12'h0, mrg, 4'hf, 1'b1, 1'b0, 1'b0, 1'b0), '0);
      if (k == 128) note(0, w0, 2);
      if (k == 129) note(0, w1, 2);
    end
    repeat (4) step('0, '0);
    wrap_up();
  end
endmodule
`default_nettype wire
